// ===== src/dmapsc_pkg.sv
package dmapsc_pkg;
  // register offsets (byte addresses)
  localparam logic [5:0] REG_CTRL = 6'h00;
  localparam logic [5:0] REG_SEC = 6'h04;
  localparam logic [5:0] REG_SRC = 6'h08;
  localparam logic [5:0] REG_DST = 6'h0C;
  localparam logic [5:0] REG_CNT = 6'h10;
  localparam logic [5:0] REG_IDX = 6'h14;
  localparam logic [5:0] REG_RLD_SRC = 6'h18;
  localparam logic [5:0] REG_RLD_DST = 6'h1C;
  localparam logic [5:0] REG_RLD_CNT = 6'h20;
  localparam logic [5:0] REG_STAT = 6'h24;
  // control field positions
  localparam int CTL_START = 0;
  localparam int CTL_SRCDIR = 2;
  localparam int CTL_DSTDIR = 4;
  localparam int CTL_AUTOINIT = 6;
  localparam int CTL_SPLIT = 7;
  localparam int CTL_FSYNC = 8;
  localparam int CTL_EMULATION_PAUSE_MODE = 9;
  localparam int CTL_READ_SYNC_SELECT = 10;
  localparam int CTL_WRITE_SYNC_SELECT = 15;
  // start field encodings
  localparam logic [1:0] START_STOP = 2'h0;
  localparam logic [1:0] START_PAUSE = 2'h2;
  // address step encodings
  localparam logic [1:0] DIR_HOLD = 2'h0;
  localparam logic [1:0] DIR_INC = 2'h1;
  localparam logic [1:0] DIR_DEC = 2'h2;
  localparam logic [1:0] DIR_INDEX = 2'h3;
  // sync select encodings
  localparam logic [4:0] SYNC_NONE = 5'h00;
  localparam logic [4:0] SYNC_PIN4 = 5'h04;
  localparam logic [4:0] SYNC_PIN7 = 5'h07;
  localparam logic [4:0] SYNC_DOORBELL = 5'h10;
  // reset values and buffer depth
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam int FIFO_DEPTH = 2;
  // channel states
  typedef enum logic [1:0] {
    DMAPSC_IDLE = 2'b00,
    DMAPSC_RUN = 2'b01,
    DMAPSC_PAUSED = 2'b10
  } dmapsc_state_t;
endpackage

// ===== src/dmapsc_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module dmapsc_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 2
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0] cnt;
  logic push;
  logic pop;
  assign in_ready_o = (cnt != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt != '0);
  assign out_data_o = mem[rp];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  // storage, content kept across any pause
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wp] <= in_data_i;
    end
  end
  // pointers and fill count
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
    end else begin
      if (push) begin
        wp <= (wp == AW'(DEPTH-1)) ? '0 : wp + 1'b1;
      end
      if (pop) begin
        rp <= (rp == AW'(DEPTH-1)) ? '0 : rp + 1'b1;
      end
      cnt <= cnt + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // dmapsc_fifo
`default_nettype wire

// ===== src/dmapsc_channel.sv
`timescale 1ns/1ps
`default_nettype none
module dmapsc_channel #(
  parameter int AW = 32,
  parameter int DW = 32
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // sync sources and emulation
  input wire logic emu_halt_i,
  input wire logic host_doorbell_event_i,
  input wire logic [7:4] external_pin_event_i,
  // read port
  output logic rd_req_o,
  output logic [AW-1:0] rd_addr_o,
  input wire logic rd_ack_i,
  input wire logic [DW-1:0] rd_data_i,
  // write port
  output logic wr_req_o,
  output logic [AW-1:0] wr_addr_o,
  output logic [DW-1:0] wr_data_o,
  input wire logic wr_ack_i,
  // status
  output logic busy_o,
  output logic paused_o
);
  import dmapsc_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // register storage
  logic [31:0] ctrl;
  logic [AW-1:0] src;
  logic [AW-1:0] dst;
  logic [15:0] elem_cnt;
  logic [15:0] frame_cnt;
  logic [15:0] elem_len;
  logic [15:0] elem_idx;
  logic [15:0] frame_idx;
  logic [AW-1:0] rld_src;
  logic [AW-1:0] rld_dst;
  logic [31:0] rld_cnt;
  logic read_sync_select_pend;
  logic write_sync_select_pend;
  logic frame_open;
  dmapsc_state_t state;
  logic [15:0] wr_elem_left;

  logic [1:0] start_f;
  logic [4:0] rsel;
  logic [4:0] wsel;
  logic autoinit;
  logic split_m;
  logic fsync;
  logic emulation_pause_mode;
  assign start_f = ctrl[CTL_START +: 2];
  assign rsel = ctrl[CTL_READ_SYNC_SELECT +: 5];
  assign wsel = ctrl[CTL_WRITE_SYNC_SELECT +: 5];
  assign autoinit = ctrl[CTL_AUTOINIT];
  assign split_m = ctrl[CTL_SPLIT];
  assign fsync = ctrl[CTL_FSYNC];
  assign emulation_pause_mode = ctrl[CTL_EMULATION_PAUSE_MODE];

  // sync event decode shared by both selects
  function automatic logic sync_hit(input logic [4:0] sel,
                                    input logic rd_side);
    if (sel == SYNC_DOORBELL) begin
      sync_hit = host_doorbell_event_i;
    end else if (rd_side && sel >= SYNC_PIN4 && sel <= SYNC_PIN7) begin
      sync_hit = external_pin_event_i[sel[2:0]];
    end else begin
      sync_hit = 1'b0;
    end
  endfunction

  // address step shared by both sides
  function automatic logic [AW-1:0] step(input logic [AW-1:0] a,
                                         input logic [1:0] dir,
                                         input logic [15:0] idx);
    unique case (dir)
      DIR_HOLD: step = a;
      DIR_INC: step = a + AW'(4);
      DIR_DEC: step = a - AW'(4);
      DIR_INDEX: step = a + AW'($signed(idx));
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // run control
  logic wb_hit;
  logic wb_wr;
  logic halted;
  logic run_ok;
  logic last_elem;
  logic rd_go;
  logic rd_done;
  logic wr_done;
  logic blk_end;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [DW-1:0] fifo_out_data;
  assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr = wb_hit && wb_we_i;
  assign halted = emu_halt_i && emulation_pause_mode;
  assign run_ok = (state == DMAPSC_RUN) && !halted;
  assign last_elem = (elem_cnt == 16'h0001);
  // reads open only when no read sync is selected, a sync is pending or a frame is already in progress
  assign rd_go = run_ok && (elem_cnt != '0) && !rd_req_o && fifo_in_ready &&
                 (rsel == SYNC_NONE || read_sync_select_pend || frame_open);
  assign rd_done = rd_req_o && rd_ack_i;
  assign wr_done = wr_req_o && wr_ack_i;
  assign blk_end = rd_done && last_elem && (frame_cnt <= 16'h0001);

  // channel state from start field only; emulation halt leaves it unchanged
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= DMAPSC_IDLE;
    end else if (start_f == START_STOP) begin
      state <= DMAPSC_IDLE;
    end else if (start_f == START_PAUSE) begin
      state <= DMAPSC_PAUSED;
    end else begin
      state <= DMAPSC_RUN;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read side: addresses, counts, reload
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_req_o <= 1'b0;
      rd_addr_o <= '0;
      src <= '0;
      elem_cnt <= '0;
      frame_cnt <= '0;
      frame_open <= 1'b0;
      elem_len <= '0;
    end else begin
      if (rd_go) begin
        rd_req_o <= 1'b1; // request holds through any pause
        rd_addr_o <= src;
        frame_open <= 1'b1;
      end
      if (rd_done) begin
        rd_req_o <= 1'b0;
        if (!last_elem) begin
          elem_cnt <= elem_cnt - 16'h0001;
          src <= step(src, ctrl[CTL_SRCDIR +: 2], elem_idx);
        end else if (blk_end) begin
          frame_open <= 1'b0;
          if (autoinit) begin
            src <= rld_src;
            elem_cnt <= rld_cnt[15:0];
            frame_cnt <= rld_cnt[31:16];
          end else begin
            elem_cnt <= '0;
            frame_cnt <= '0;
          end
        end else begin
          frame_open <= !fsync;
          elem_cnt <= elem_len;
          frame_cnt <= frame_cnt - 16'h0001;
          if (split_m && ctrl[CTL_SRCDIR +: 2] == DIR_INDEX) begin
            src <= src + AW'($signed(frame_idx));
          end else begin
            src <= step(src, ctrl[CTL_SRCDIR +: 2], elem_idx);
          end
        end
      end else if (wb_wr && wb_adr_i == REG_SRC) begin
        src <= wb_dat_i[AW-1:0];
      end else if (wb_wr && wb_adr_i == REG_CNT) begin
        elem_cnt <= wb_dat_i[15:0];
        frame_cnt <= wb_dat_i[31:16];
        if (state != DMAPSC_RUN) begin
          elem_len <= wb_dat_i[15:0];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // internal buffer; writes that drain it are issued only while running
  dmapsc_fifo #(
    .WIDTH(DW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(rd_done),
    .in_ready_o(fifo_in_ready),
    .in_data_i(rd_data_i),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(wr_done),
    .out_data_o(fifo_out_data)
  );

  ////////////////////////////////////////////////////////////////////////
  // write side
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_req_o <= 1'b0;
      wr_addr_o <= '0;
      wr_data_o <= '0;
      dst <= '0;
    end else if (wr_done) begin
      wr_req_o <= 1'b0;
      if (blk_end && autoinit) begin
        dst <= rld_dst;
      end else begin
        dst <= step(dst, ctrl[CTL_DSTDIR +: 2], elem_idx);
      end
    end else if (!wr_req_o && run_ok && fifo_out_valid &&
                 (wsel == SYNC_NONE || write_sync_select_pend)) begin
      wr_req_o <= 1'b1;
      wr_addr_o <= dst;
      wr_data_o <= fifo_out_data;
    end else if (wb_wr && wb_adr_i == REG_DST) begin
      dst <= wb_dat_i[AW-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sync pending flags: event set wins over consume or software clear
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      read_sync_select_pend <= 1'b0;
      write_sync_select_pend <= 1'b0;
    end else begin
      if (sync_hit(rsel, 1'b1)) begin
        read_sync_select_pend <= 1'b1;
      end else if (wb_wr && wb_adr_i == REG_SEC) begin
        read_sync_select_pend <= wb_dat_i[0];
      end else if (rd_go && !frame_open) begin
        read_sync_select_pend <= 1'b0;
      end
      if (sync_hit(wsel, 1'b0)) begin
        write_sync_select_pend <= 1'b1;
      end else if (wb_wr && wb_adr_i == REG_SEC) begin
        write_sync_select_pend <= wb_dat_i[1];
      end else if (wr_done || (wr_req_o && 1'b0)) begin
        write_sync_select_pend <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // configuration registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl <= RST_WORD;
      elem_idx <= '0;
      frame_idx <= '0;
      rld_src <= '0;
      rld_dst <= '0;
      rld_cnt <= RST_WORD;
    end else if (wb_wr) begin
      unique case (wb_adr_i)
        REG_CTRL: ctrl <= wb_dat_i;
        REG_IDX: begin
          elem_idx <= wb_dat_i[15:0];
          frame_idx <= wb_dat_i[31:16];
        end
        REG_RLD_SRC: rld_src <= wb_dat_i[AW-1:0];
        REG_RLD_DST: rld_dst <= wb_dat_i[AW-1:0];
        REG_RLD_CNT: rld_cnt <= wb_dat_i;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bus answer and status outputs
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
      busy_o <= 1'b0;
      paused_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_hit;
      busy_o <= (state == DMAPSC_RUN) && (elem_cnt != '0 || fifo_out_valid);
      // follows the start field directly so it changes on the same edge as the state
      paused_o <= (start_f == START_PAUSE) || halted;
      if (wb_hit && !wb_we_i) begin
        unique case (wb_adr_i)
          REG_CTRL: wb_dat_o <= ctrl;
          REG_SEC: wb_dat_o <= {30'h0, write_sync_select_pend, read_sync_select_pend};
          REG_SRC: wb_dat_o <= 32'(src);
          REG_DST: wb_dat_o <= 32'(dst);
          REG_CNT: wb_dat_o <= {frame_cnt, elem_cnt};
          REG_IDX: wb_dat_o <= {frame_idx, elem_idx};
          REG_RLD_SRC: wb_dat_o <= 32'(rld_src);
          REG_RLD_DST: wb_dat_o <= 32'(rld_dst);
          REG_RLD_CNT: wb_dat_o <= rld_cnt;
          REG_STAT: wb_dat_o <= {28'h0, fifo_out_valid, frame_open,
                                 2'(state)};
          default: wb_dat_o <= '0;
        endcase
      end
    end
  end
endmodule // dmapsc_channel
`default_nettype wire

// ===== dv/dmapsc_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module dmapsc_mem_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // answer delays in cycles
  input wire logic [3:0] rd_lat_i,
  input wire logic [3:0] wr_lat_i,
  // read side
  input wire logic rd_req_i,
  input wire logic [31:0] rd_addr_i,
  output logic rd_ack_o,
  output logic [31:0] rd_data_o,
  // write side
  input wire logic wr_req_i,
  output logic wr_ack_o
);
  logic [3:0] rd_wait;
  logic [3:0] wr_wait;
  // read answer after the delay; data toggles while not valid
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_ack_o <= 1'b0;
      rd_wait <= 4'h0;
      rd_data_o <= 32'h0;
    end else if (rd_req_i && !rd_ack_o && rd_wait >= rd_lat_i) begin
      rd_ack_o <= 1'b1;
      rd_wait <= 4'h0;
      rd_data_o <= {rd_addr_i[15:0], ~rd_addr_i[15:0]};
    end else begin
      rd_ack_o <= 1'b0;
      rd_wait <= (rd_req_i && !rd_ack_o) ? rd_wait + 4'h1 : 4'h0;
      rd_data_o <= ~rd_data_o;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // write answer after the delay
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ack_o <= 1'b0;
      wr_wait <= 4'h0;
    end else if (wr_req_i && !wr_ack_o && wr_wait >= wr_lat_i) begin
      wr_ack_o <= 1'b1;
      wr_wait <= 4'h0;
    end else begin
      wr_ack_o <= 1'b0;
      wr_wait <= (wr_req_i && !wr_ack_o) ? wr_wait + 4'h1 : 4'h0;
    end
  end
endmodule // dmapsc_mem_model
`default_nettype wire

// ===== dv/dmapsc_sva.sv
`timescale 1ns/1ps
`default_nettype none
module dmapsc_sva #(
  parameter int AW = 32,
  parameter int DW = 32
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // register bus and halt
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  input wire logic emu_halt_i,
  // memory ports and status
  input wire logic rd_req_o,
  input wire logic [AW-1:0] rd_addr_o,
  input wire logic rd_ack_i,
  input wire logic wr_req_o,
  input wire logic [AW-1:0] wr_addr_o,
  input wire logic [DW-1:0] wr_data_o,
  input wire logic wr_ack_i,
  input wire logic paused_o
);
  import dmapsc_pkg::*;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  logic ctl_wr;
  logic emulation_pause_mode_q;
  // control write taken at this edge
  assign ctl_wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o
    && wb_adr_i == REG_CTRL;
  // last emulation pause mode written
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i)
      emulation_pause_mode_q <= 1'b0;
    else if (ctl_wr)
      emulation_pause_mode_q <= wb_dat_i[CTL_EMULATION_PAUSE_MODE];
  end
  // no new request while paused
  property quiet(req);
    paused_o && !req && !wb_cyc_i && !$fell(emu_halt_i) |=> !req;
  endproperty
  ////////////////////////////////////////////////////////////////////////////
  ack_next_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus ack late");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus ack too long");
  rd_hold_a: assert property (rd_req_o && !rd_ack_i |=>
    rd_req_o && $stable(rd_addr_o)) else $error("read request dropped");
  wr_hold_a: assert property (wr_req_o && !wr_ack_i |=> wr_req_o
    && $stable(wr_addr_o) && $stable(wr_data_o)) else $error("write moved");
  pause_req_a: assert property (
    ctl_wr && wb_dat_i[1:0] == START_PAUSE |-> ##[1:2] paused_o)
    else $error("pause not taken");
  run_req_a: assert property (
    ctl_wr && wb_dat_i[0] && !emu_halt_i |-> ##[1:2] !paused_o)
    else $error("run not taken");
  emu_pause_a: assert property (
    (emulation_pause_mode_q && emu_halt_i) [*3] |-> paused_o) else $error("halt ignored");
  rd_quiet_a: assert property (quiet(rd_req_o))
    else $error("read while paused");
  wr_quiet_a: assert property (quiet(wr_req_o))
    else $error("write while paused");
  reset_quiet_a: assert property ($fell(rst_i) |->
    !rd_req_o && !wr_req_o && !wb_ack_o && !paused_o)
    else $error("outputs busy after reset");
  // main scenarios
  cover property (paused_o && emu_halt_i);
  cover property (rd_req_o && rd_ack_i);
  cover property (wr_req_o && wr_ack_i);
endmodule // dmapsc_sva
bind dmapsc_channel dmapsc_sva #(.AW(AW), .DW(DW)) u_sva (.*);
`default_nettype wire

// ===== dv/dma_channel_pause_sync_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module dma_channel_pause_sync_control_tb_top;
  import dmapsc_pkg::*;
  logic clk_i, rst_i, cyc, stb, we, halt, bell;
  logic wb_ack_o, rd_req_o, rd_ack_i, wr_req_o, wr_ack_i, paused_o, busy_o;
  logic [5:0] adr;
  logic [7:4] pins;
  logic [3:0] rlat, wlat;
  logic [31:0] dat, q, wb_dat_o, rd_addr_o, rd_data_i, wr_addr_o, wr_data_o;
  logic [31:0] wa[$], wd[$];
  int n_rd, err_total, n_checks;
  // 40 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  dmapsc_channel dut (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
    .wb_dat_o, .wb_ack_o, .emu_halt_i(halt), .host_doorbell_event_i(bell),
    .external_pin_event_i(pins), .rd_req_o, .rd_addr_o, .rd_ack_i,
    .rd_data_i, .wr_req_o, .wr_addr_o, .wr_data_o, .wr_ack_i,
    .busy_o, .paused_o);
  dmapsc_mem_model mem (.clk_i, .rst_i, .rd_lat_i(rlat), .wr_lat_i(wlat),
    .rd_req_i(rd_req_o), .rd_addr_i(rd_addr_o), .rd_ack_o(rd_ack_i),
    .rd_data_o(rd_data_i), .wr_req_i(wr_req_o), .wr_ack_o(wr_ack_i));
  // log completed writes, count completed reads
  always @(posedge clk_i) begin
    if (wr_req_o && wr_ack_i) begin
      wa.push_back(wr_addr_o);
      wd.push_back(wr_data_o);
    end
    if (rd_req_o && rd_ack_i)
      n_rd++;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic fail(input string s);
    $display("Error %s wait ran out", s);
    err_total++;
    close_out();
  endtask
  task automatic chk(input string s, input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask
  // one classic bus cycle; read data lands in q
  task automatic wb(input logic [5:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    for (int k = 0; k < 40 && wb_ack_o !== 1'b1; k++) @(posedge clk_i);
    if (wb_ack_o !== 1'b1)
      fail("bus ack");
    q = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wait_wr(input int n);
    for (int k = 0; k < 800 && wa.size() < n; k++) @(posedge clk_i);
    if (wa.size() < n)
      fail("write");
  endtask
  function automatic logic [31:0] cw(logic [1:0] st, logic [4:0] rs,
      logic [4:0] ws, logic em);
    return {12'h000, ws, rs, em, 3'h0, DIR_INC, DIR_INC, st};
  endfunction
  // stop, clear pending, program and start
  task automatic go(input logic [31:0] ctl, input logic [15:0] n);
    wb(REG_CTRL, 1'b1, 32'h0);
    wb(REG_SEC, 1'b1, 32'h0);
    wa.delete();
    wd.delete();
    n_rd = 0;
    wb(REG_SRC, 1'b1, 32'h1000);
    wb(REG_DST, 1'b1, 32'h2000);
    wb(REG_CNT, 1'b1, {16'h0001, n});
    wb(REG_CTRL, 1'b1, ctl);
  endtask
  task automatic chk_all(input int n);
    for (int i = 0; i < n; i++) begin
      chk("write addr", wa[i], 32'h2000 + 4 * i);
      chk("write data", wd[i], {16'h1000 + 16'(4 * i), ~(16'h1000 + 16'(4 * i))});
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    wb(REG_CTRL, 1'b0, 32'h0);
    chk("ctrl reset", q, RST_WORD);
    wb(REG_SRC, 1'b1, 32'h0000_1234);
    wb(REG_SRC, 1'b0, 32'h0);
    chk("src", q, 32'h0000_1234);
    wb(6'h3C, 1'b1, 32'hFFFF_FFFF);
    wb(6'h3C, 1'b0, 32'h0);
    chk("unmapped", q, 32'h0);
    $display("register test done");
  endtask
  task automatic t_copy();
    wlat <= 4'h5;
    go(cw(2'h1, SYNC_NONE, SYNC_NONE, 1'b0), 16'h0004);
    wait_wr(4);
    chk_all(4);
    repeat (4) @(posedge clk_i);
    chk("idle busy", 32'(busy_o), 32'h0);
    wlat <= 4'h0;
    $display("copy test done");
  endtask
  task automatic t_pause();
    logic [31:0] s;
    int k;
    rlat <= 4'h3;
    wlat <= 4'h6;
    go(cw(2'h1, SYNC_NONE, SYNC_NONE, 1'b0), 16'h0005);
    wait_wr(1);
    wb(REG_CTRL, 1'b1, cw(START_PAUSE, SYNC_NONE, SYNC_NONE, 1'b0));
    repeat (30) @(posedge clk_i);
    chk("paused", 32'(paused_o), 32'h1);
    wb(REG_SRC, 1'b0, 32'h0);
    s = q;
    k = wa.size();
    repeat (20) @(posedge clk_i);
    wb(REG_SRC, 1'b0, 32'h0);
    chk("held src", q, s);
    chk("held writes", 32'(wa.size()), 32'(k));
    wb(REG_SEC, 1'b1, 32'h1);
    wb(REG_CNT, 1'b0, 32'h0);
    wb(REG_CNT, 1'b1, q);
    wb(REG_CTRL, 1'b1, cw(2'h3, SYNC_NONE, SYNC_NONE, 1'b0));
    wait_wr(5);
    chk_all(5);
    rlat <= 4'h0;
    wlat <= 4'h0;
    $display("pause test done");
  endtask
  task automatic t_emu();
    halt <= 1'b1;
    go(cw(2'h1, SYNC_NONE, SYNC_NONE, 1'b1), 16'h0002);
    repeat (20) @(posedge clk_i);
    chk("halt paused", 32'(paused_o), 32'h1);
    chk("halt held", 32'(wa.size()), 32'h0);
    chk("halt busy", 32'(busy_o), 32'h1);
    wb(REG_CNT, 1'b0, 32'h0);
    wb(REG_CNT, 1'b1, q);
    wb(REG_SEC, 1'b1, 32'h1);
    halt <= 1'b0;
    wait_wr(2);
    halt <= 1'b1;
    go(cw(2'h1, SYNC_NONE, SYNC_NONE, 1'b0), 16'h0002);
    wait_wr(2);
    chk_all(2);
    halt <= 1'b0;
    $display("halt test done");
  endtask
  task automatic t_sync();
    logic [4:0] sel[5] = '{SYNC_PIN4, 5'h05, 5'h06, SYNC_PIN7, SYNC_DOORBELL};
    for (int i = 0; i < 6; i++) begin
      if (i < 5)
        go(cw(2'h1, sel[i], SYNC_NONE, 1'b0), 16'h0001);
      else
        go(cw(2'h1, SYNC_NONE, SYNC_DOORBELL, 1'b0), 16'h0001);
      repeat (20) @(posedge clk_i);
      chk("before sync", 32'(wa.size()), 32'h0);
      if (i < 4)
        pins <= 4'h1 << i;
      else
        bell <= 1'b1;
      @(posedge clk_i);
      pins <= 4'h0;
      bell <= 1'b0;
      wait_wr(1);
      chk("after sync", 32'(wa.size()), 32'h1);
    end
    $display("sync test done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_i = 1'b1;
    {cyc, stb, we, halt, bell} = 5'h00;
    adr = 6'h00;
    dat = 32'h0;
    pins = 4'h0;
    rlat = 4'h0;
    wlat = 4'h0;
    err_total = 0;
    n_checks = 0;
    n_rd = 0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_copy();
    t_pause();
    t_emu();
    t_sync();
    close_out();
  end
endmodule // dma_channel_pause_sync_control_tb_top
`default_nettype wire
